// ### verilog/cfp_pkg.sv
package cfp_pkg;
    // ****************************************
    // geometry
    // ****************************************
    localparam int CFP_PAGE_BYTES = 128;
    localparam int CFP_PAGES = 128;
    localparam int CFP_ARRAY_BYTES = CFP_PAGE_BYTES * CFP_PAGES;
    localparam int CFP_OFS_W = 7;
    localparam int CFP_PAGE_W = 7;
    localparam logic [15:0] CFP_EXTRA_ROW_BASE = 16'hFF80;
    localparam logic [15:0] CFP_BOOT_BASE = 16'hF800;
    localparam logic [15:0] CFP_USER_TOP = 16'h3FFF;
    localparam int CFP_BOOT_BYTES = 2048;
    // ****************************************
    // control register layout
    // ****************************************
    localparam int CFP_KEY_LSB = 4;
    localparam int CFP_MAP_BIT = 3;
    localparam int CFP_SPACE_LSB = 1;
    localparam int CFP_BUSY_BIT = 0;
    localparam logic [7:0] CFP_CTRL_RESET = 8'h00;
    localparam logic [3:0] CFP_KEY_FIRST = 4'h5;
    localparam logic [3:0] CFP_KEY_SECOND = 4'hA;
    localparam logic [1:0] CFP_SPACE_USER = 2'b00;
    localparam logic [1:0] CFP_SPACE_EXTRA_ROW = 2'b01;
    localparam logic [1:0] CFP_SPACE_SEC = 2'b10;
    localparam logic [1:0] CFP_SPACE_RSVD = 2'b11;
    localparam int CFP_AUX_BOOT_BIT = 5;
    localparam logic [7:0] CFP_SEC_RESET = 8'hFF;
    localparam logic [3:0] CFP_SEC_HW_DEFAULT = 4'hF;
    // ****************************************
    // timing
    // ****************************************
    localparam int CFP_CLK_MHZ = 10;
    localparam int CFP_CELL_TIME_US = 1;
    localparam int CFP_CELL_CYCLES = CFP_CELL_TIME_US * CFP_CLK_MHZ;
    // ****************************************
    // avalon register offsets (word index -> byte address)
    // ****************************************
    localparam logic [3:0] CFP_REG_CTRL = 4'h0;
    localparam logic [3:0] CFP_REG_AUX = 4'h4;
    localparam logic [3:0] CFP_REG_LATCH = 4'h8;
    localparam logic [3:0] CFP_REG_CODE = 4'hC;
    typedef enum logic [3:0] {
        CFP_IDLE = 4'b0001,
        CFP_ERASE = 4'b0010,
        CFP_PROG = 4'b0100,
        CFP_DONE = 4'b1000
    } cfp_state_t;
endpackage

// ### verilog/cfp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface cfp_if;
    logic sfr_wr;
    logic sfr_sel_aux;
    logic [7:0] sfr_wdata;
    logic [7:0] ctrl_rd;
    logic [7:0] aux_rd;
    logic data_wr;
    logic ext_ram_sel;
    logic [15:0] data_addr;
    logic [7:0] data_wdata;
    logic latch_taken;
    logic code_rd;
    logic [15:0] code_addr;
    logic [7:0] code_rdata;
    logic code_valid;
    logic cpu_idle;
    modport dev (
        input sfr_wr, sfr_sel_aux, sfr_wdata, data_wr, ext_ram_sel, data_addr,
        input data_wdata, code_rd, code_addr,
        output ctrl_rd, aux_rd, latch_taken, code_rdata, code_valid, cpu_idle
    );
    modport cpu (
        output sfr_wr, sfr_sel_aux, sfr_wdata, data_wr, ext_ram_sel, data_addr,
        output data_wdata, code_rd, code_addr,
        input ctrl_rd, aux_rd, latch_taken, code_rdata, code_valid, cpu_idle
    );
endinterface
`default_nettype wire

// ### verilog/cfp_flash_dev.sv
// Contract
// R1 - user array 128 pages of 128 bytes
// R2 - separate 128-byte extra row
// R3 - security byte: upper nibble writable only
// R4 - page latch buffer is sole write path
// R5 - code reads array; map bit steers writes
// R6 - address bits 6..0 offset, 13..7 page
// R7 - map bit overrides external-ram select
// R8 - space select picks code-read view
// R9 - launch needs key 5 then A
// R10 - key A programs selected space; 11 none
// R11 - busy flash holds cpu idle till done
// R12 - busy flag hardware set and cleared
// R13 - boot select maps boot bank at F800h
// R14 - any 1..128 loaded bytes accepted
// R15 - erase then program loaded bytes only
// R16 - page from most recent latch write
// R17 - software masks interrupts while busy
// R18 - software uses full launch byte pairs
// R19 - security: 0Ch, load 0000h, launch
// R20 - reads: 00h, 02h, 04h then fetch
// R21 - control bits key/map/space/busy, reset zero
// R22 - anything but A after 5 cancels; here only control writes cancel, aux and latch writes keep it armed
`timescale 1ns/100ps
`default_nettype none
module cfp_flash_dev
    import cfp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    cfp_if.dev bus,
    output logic [3:0] sec_hw_bits_o
);
    // ****************************************
    // storage
    // ****************************************
    logic [7:0] array_q [CFP_ARRAY_BYTES]; // R1
    logic [7:0] extra_row_q [CFP_PAGE_BYTES]; // R2
    logic [7:0] boot_q [CFP_BOOT_BYTES];
    logic [7:0] sec_q;
    logic [7:0] latch_q [CFP_PAGE_BYTES]; // R4
    logic [CFP_PAGE_BYTES-1:0] loaded_q;
    logic [CFP_PAGE_W-1:0] page_q;
    logic [7:0] ctrl_q;
    logic [7:0] aux_q;
    logic armed_q;
    logic [1:0] prog_space_q;
    cfp_state_t state_q;
    logic [7:0] cnt_q;
    logic [CFP_OFS_W-1:0] idx_q;
    logic [7:0] rdata_q;
    logic valid_q;

    // ****************************************
    // decode
    // ****************************************
    wire logic [3:0] wr_key = bus.sfr_wdata[CFP_KEY_LSB +: 4];
    wire logic [1:0] space = ctrl_q[CFP_SPACE_LSB +: 2];
    wire logic map_on = ctrl_q[CFP_MAP_BIT];
    wire logic busy = (state_q != CFP_IDLE);
    wire logic ctrl_wr = bus.sfr_wr && !bus.sfr_sel_aux && !busy;
    wire logic aux_wr = bus.sfr_wr && bus.sfr_sel_aux && !busy;
    wire logic launch = ctrl_wr && armed_q && (wr_key == CFP_KEY_SECOND)
        && (space != CFP_SPACE_RSVD); // R9 R10
    wire logic latch_wr = bus.data_wr && map_on && !busy; // R5 R7
    wire logic [CFP_OFS_W-1:0] wr_ofs = bus.data_addr[6:0]; // R6
    wire logic [CFP_PAGE_W-1:0] wr_page = bus.data_addr[13:7]; // R6
    wire logic cell_tick = (cnt_q == 8'(CFP_CELL_CYCLES - 1));
    wire logic last_idx = (idx_q == 7'(CFP_PAGE_BYTES - 1));

    assign bus.ctrl_rd = {ctrl_q[7:1], busy}; // R12 R21
    assign bus.aux_rd = aux_q;
    assign bus.latch_taken = latch_wr;
    assign bus.cpu_idle = busy; // R11
    assign bus.code_rdata = rdata_q;
    assign bus.code_valid = valid_q;
    assign sec_hw_bits_o = sec_q[3:0];

    // ****************************************
    // control and key sequence
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ctrl_q <= CFP_CTRL_RESET; // R21
            aux_q <= 8'h00;
            armed_q <= 1'b0;
            prog_space_q <= CFP_SPACE_USER;
        end else begin
            if (ctrl_wr) begin
                ctrl_q <= {bus.sfr_wdata[7:1], 1'b0};
                armed_q <= (wr_key == CFP_KEY_FIRST); // R9 R22
            end
            if (launch) begin
                prog_space_q <= space; // R10
            end
            if (aux_wr) begin
                aux_q <= bus.sfr_wdata;
            end
        end
    end

    // ****************************************
    // latch loading
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            loaded_q <= '0;
            page_q <= '0;
        end else if (latch_wr) begin
            latch_q[wr_ofs] <= bus.data_wdata; // R4 R14
            loaded_q[wr_ofs] <= 1'b1;
            page_q <= wr_page; // R16
        end else if (state_q == CFP_DONE) begin
            loaded_q <= '0;
        end
    end

    // ****************************************
    // erase / program sequencer
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= CFP_IDLE;
            cnt_q <= 8'h00;
            idx_q <= '0;
            sec_q <= CFP_SEC_RESET;
        end else begin
            unique case (state_q)
                CFP_IDLE: begin
                    cnt_q <= 8'h00;
                    idx_q <= '0;
                    if (launch) begin
                        state_q <= CFP_ERASE; // R11 R12
                    end
                end
                CFP_ERASE: begin
                    cnt_q <= cell_tick ? 8'h00 : cnt_q + 8'h01;
                    if (cell_tick) begin
                        if (loaded_q[idx_q]) begin // R15
                            unique case (prog_space_q)
                                CFP_SPACE_USER: array_q[{page_q, idx_q}] <= 8'hFF;
                                CFP_SPACE_EXTRA_ROW: extra_row_q[idx_q] <= 8'hFF;
                                default: sec_q[7:4] <= 4'hF;
                            endcase
                        end
                        idx_q <= idx_q + 7'd1;
                        if (last_idx) begin
                            state_q <= CFP_PROG;
                        end
                    end
                end
                CFP_PROG: begin
                    cnt_q <= cell_tick ? 8'h00 : cnt_q + 8'h01;
                    if (cell_tick) begin
                        if (loaded_q[idx_q]) begin // R15
                            unique case (prog_space_q)
                                CFP_SPACE_USER: array_q[{page_q, idx_q}] <= latch_q[idx_q];
                                CFP_SPACE_EXTRA_ROW: extra_row_q[idx_q] <= latch_q[idx_q];
                                default: begin
                                    if (idx_q == '0) begin
                                        sec_q[7:4] <= latch_q[0][7:4]; // R3
                                    end
                                end
                            endcase
                        end
                        idx_q <= idx_q + 7'd1;
                        if (last_idx) begin
                            state_q <= CFP_DONE;
                        end
                    end
                end
                CFP_DONE: begin
                    state_q <= CFP_IDLE; // R11 R12
                end
                default: state_q <= CFP_IDLE;
            endcase
        end
    end

    // ****************************************
    // boot bank contents
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < CFP_BOOT_BYTES; i++) begin
                boot_q[i] <= 8'hFF;
            end
        end
    end

    // ****************************************
    // code-space read
    // ****************************************
    wire logic boot_hit = aux_q[CFP_AUX_BOOT_BIT] && (bus.code_addr >= CFP_BOOT_BASE); // R13
    wire logic extra_row_hit = (bus.code_addr >= CFP_EXTRA_ROW_BASE);
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rdata_q <= 8'h00;
            valid_q <= 1'b0;
        end else begin
            valid_q <= bus.code_rd && !busy; // R11
            if (bus.code_rd && !busy) begin
                if (boot_hit) begin
                    rdata_q <= boot_q[bus.code_addr[10:0]]; // R13
                end else begin
                    unique case (space) // R8
                        CFP_SPACE_USER: rdata_q <= (bus.code_addr <= CFP_USER_TOP)
                            ? array_q[bus.code_addr[13:0]] : 8'hFF; // R5
                        CFP_SPACE_EXTRA_ROW: rdata_q <= extra_row_hit
                            ? extra_row_q[bus.code_addr[6:0]] : 8'hFF;
                        CFP_SPACE_SEC: rdata_q <= (bus.code_addr == 16'h0000)
                            ? sec_q : 8'hFF;
                        default: rdata_q <= 8'hFF;
                    endcase
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### verilog/cfp_cpu_end.sv
`timescale 1ns/100ps
`default_nettype none
module cfp_cpu_end
    import cfp_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    cfp_if.cpu bus,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_masked_o
);
    // ****************************************
    // avalon decode
    // ****************************************
    logic ack_q;
    logic [31:0] rdata_q;
    logic code_pend_q;
    logic mask_q;
    wire logic sel_ctrl = (avs_address_i == CFP_REG_CTRL);
    wire logic sel_aux = (avs_address_i == CFP_REG_AUX);
    wire logic sel_latch = (avs_address_i == CFP_REG_LATCH);
    wire logic sel_code = (avs_address_i == CFP_REG_CODE);
    wire logic req = (avs_read_i || avs_write_i) && !ack_q;
    wire logic code_req = avs_read_i && sel_code && !ack_q && !code_pend_q;
    wire logic code_back = code_pend_q && bus.code_valid;
    wire logic plain_done = req && !(avs_read_i && sel_code);
    wire logic hold = sel_latch && avs_write_i && bus.cpu_idle;

    assign avs_waitrequest_o = !ack_q;
    assign avs_readdata_o = rdata_q;
    assign irq_masked_o = mask_q; // R17
    assign bus.sfr_wr = avs_write_i && !ack_q && (sel_ctrl || sel_aux); // R18
    assign bus.sfr_sel_aux = sel_aux;
    assign bus.sfr_wdata = avs_writedata_i[7:0];
    assign bus.data_wr = avs_write_i && !ack_q && sel_latch && !bus.cpu_idle;
    assign bus.ext_ram_sel = avs_writedata_i[24];
    assign bus.data_addr = avs_writedata_i[23:8];
    assign bus.data_wdata = avs_writedata_i[7:0];
    assign bus.code_rd = code_req && !bus.cpu_idle;
    assign bus.code_addr = avs_writedata_i[15:0];

    // ****************************************
    // answer
    // ****************************************
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            code_pend_q <= 1'b0;
            mask_q <= 1'b0;
        end else begin
            ack_q <= (plain_done && !hold) || code_back;
            mask_q <= bus.cpu_idle; // R17
            if (bus.code_rd) begin
                code_pend_q <= 1'b1;
            end else if (code_back) begin
                code_pend_q <= 1'b0;
            end
            if (code_back) begin
                rdata_q <= {24'h00_0000, bus.code_rdata}; // R20
            end else if (avs_read_i && sel_ctrl) begin
                rdata_q <= {24'h00_0000, bus.ctrl_rd};
            end else if (avs_read_i && sel_aux) begin
                rdata_q <= {24'h00_0000, bus.aux_rd};
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/cfp_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module cfp_asserts (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic sfr_wr,
    input wire logic sfr_sel_aux,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] ctrl_rd,
    input wire logic data_wr,
    input wire logic latch_taken,
    input wire logic code_rd,
    input wire logic code_valid,
    input wire logic cpu_idle
);
    // ********
    // helpers
    // ********
    localparam int BUSY_MIN = 2560;
    localparam int BUSY_MAX = 2562;
    logic armed_q;
    logic [11:0] busy_cnt_q;
    wire ctrl_wr = sfr_wr && !sfr_sel_aux && !cpu_idle;
    wire key_a = sfr_wdata[7:4] == 4'hA;
    wire rsvd = ctrl_rd[2:1] == 2'b11;
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            armed_q <= 1'b0;
            busy_cnt_q <= 12'h000;
        end else begin
            if (ctrl_wr) begin
                armed_q <= sfr_wdata[7:4] == 4'h5;
            end
            busy_cnt_q <= cpu_idle ? busy_cnt_q + 12'h001 : 12'h000;
        end
    end
    // ********
    // checks
    // ********
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    chk_busy_mirror: assert property (ctrl_rd[0] == cpu_idle)
        else $error("busy flag and idle differ");
    chk_launch_busy: assert property (ctrl_wr && key_a && armed_q && !rsvd |=> cpu_idle)
        else $error("launch did not start");
    chk_no_launch: assert property (ctrl_wr && key_a && (!armed_q || rsvd) |=> !cpu_idle)
        else $error("launch without unlock");
    chk_busy_min: assert property ($fell(cpu_idle) |-> busy_cnt_q >= BUSY_MIN)
        else $error("programming too short");
    chk_busy_max: assert property (busy_cnt_q <= BUSY_MAX)
        else $error("idle not released");
    chk_valid_follows: assert property (code_rd && !cpu_idle |=> code_valid)
        else $error("code read not answered");
    chk_latch_gate: assert property (latch_taken |-> data_wr && ctrl_rd[3])
        else $error("latch taken without map");
    chk_latch_take: assert property (data_wr && ctrl_rd[3] && !cpu_idle |-> latch_taken)
        else $error("mapped latch write dropped");
    chk_ctrl_store: assert property (ctrl_wr |=> ctrl_rd[7:1] == $past(sfr_wdata[7:1]))
        else $error("control fields not stored");
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module tb_top;
    import cfp_pkg::*;
    logic core_clk_i;
    logic reset_i;
    logic [3:0] av_addr;
    logic av_rd;
    logic av_wr;
    logic [31:0] av_wdata;
    logic [31:0] av_rdata;
    logic av_wait;
    logic irq_masked;
    logic [3:0] sec_hw;
    int n_mismatch;
    int tests_run;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] e_v;
    logic [31:0] m_v;
    logic [6:0] pg;
    logic [7:0] dat[10];
    cfp_if bus_if();
    cfp_flash_dev u_cfp_flash_dev (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .bus(bus_if.dev), .sec_hw_bits_o(sec_hw));
    cfp_cpu_end u_cfp_cpu_end (.core_clk_i(core_clk_i), .reset_i(reset_i), .bus(bus_if.cpu),
        .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
        .avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata),
        .avs_waitrequest_o(av_wait), .irq_masked_o(irq_masked));
    cfp_asserts u_cfp_asserts (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .sfr_wr(bus_if.sfr_wr), .sfr_sel_aux(bus_if.sfr_sel_aux), .sfr_wdata(bus_if.sfr_wdata),
        .ctrl_rd(bus_if.ctrl_rd), .data_wr(bus_if.data_wr), .latch_taken(bus_if.latch_taken),
        .code_rd(bus_if.code_rd), .code_valid(bus_if.code_valid), .cpu_idle(bus_if.cpu_idle));
    // ********
    // bus tasks
    // ********
    task automatic acc(input logic rd, input logic [3:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic [31:0] m);
        @(posedge core_clk_i);
        if (rd) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        av_addr <= a;
        av_wdata <= d;
        av_rd <= rd;
        av_wr <= !rd;
        do begin
            @(posedge core_clk_i);
        end while (av_wait !== 1'b0);
        av_rd <= 1'b0;
        av_wr <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        acc(1'b0, a, d, '0, '0);
    endtask
    task automatic code(input logic [15:0] a, input logic [7:0] e);
        acc(1'b1, 4'hC, {16'h0000, a}, {24'h00_0000, e}, 32'h0000_00FF);
    endtask
    task automatic launch(input logic [7:0] k1, input logic [7:0] k2, input logic mid);
        int n;
        wr(4'h0, {24'h00_0000, k1});
        if (mid) wr(4'h4, 32'h0000_0000);
        wr(4'h0, {24'h00_0000, k2});
        n = 0;
        while (irq_masked !== 1'b1 && n < 5) begin
            @(posedge core_clk_i);
            n++;
        end
        `CHK(irq_masked, 1'b1)
        wr(4'h0, 32'h0000_0000);
        acc(1'b1, 4'h0, 0, 32'h0000_0001, 32'h0000_0001);
        n = 0;
        while (bus_if.cpu_idle !== 1'b0 && n < 4000) begin
            @(posedge core_clk_i);
            n++;
        end
        acc(1'b1, 4'h0, 0, 32'h0000_0000, 32'h0000_0001);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ********
    // monitor
    // ********
    always @(posedge core_clk_i) begin
        if (av_rd && av_wait === 1'b0) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
            end else begin
                e_v = exp_q.pop_front();
                m_v = msk_q.pop_front();
                `CHK(av_rdata & m_v, e_v)
            end
        end
    end
    initial begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (40000) @(posedge core_clk_i);
        n_mismatch++;
        test_done;
    end
    // ********
    // tests
    // ********
    initial begin
        reset_i = 1'b1;
        av_addr = 4'h0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_wdata = 32'h0000_0000;
        n_mismatch = 0;
        tests_run = 0;
        void'($urandom(32'h801c));
        repeat (12) @(posedge core_clk_i);
        reset_i <= 1'b0;
        acc(1'b1, 4'h0, 0, 32'h0000_0000, 32'hFFFF_FFFF);
        acc(1'b1, 4'h2, 0, 32'h0000_0000, 32'hFFFF_FFFF);
        wr(4'h4, 32'h0000_0020);
        acc(1'b1, 4'h4, 0, 32'h0000_0020, 32'hFFFF_FFFF);
        wr(4'h4, 32'h0000_0000);
        `CHK(sec_hw, 4'hF)
        $display("test reset done");
        pg = 7'($urandom_range(127, 0));
        for (int i = 0; i < 10; i++) dat[i] = 8'($urandom);
        wr(4'h0, 32'h0000_0008);
        for (int i = 0; i < 4; i++) wr(4'h8, {8'h00, 2'b00, pg, 7'(i), dat[i]});
        launch(8'h50, 8'hA0, 1'b0);
        wr(4'h0, 32'h0000_0008);
        wr(4'h8, {8'h00, 2'b00, pg + 7'h01, 7'h02, 8'h3C});
        for (int i = 2; i < 6; i++) wr(4'h8, {8'h01, 2'b00, pg, 7'(i), dat[i + 4]});
        launch(8'h50, 8'hA0, 1'b1);
        wr(4'h0, 32'h0000_0000);
        for (int i = 0; i < 6; i++) code({2'b00, pg, 7'(i)}, i < 2 ? dat[i] : dat[i + 4]);
        $display("test user page done");
        wr(4'h0, 32'h0000_0008);
        wr(4'h8, {8'h00, 16'hFF80, 8'hA5});
        wr(4'h8, {8'h00, 16'hFF81, 8'h3C});
        launch(8'h52, 8'hA2, 1'b0);
        wr(4'h0, 32'h0000_0002);
        code(16'hFF80, 8'hA5);
        code(16'hFF81, 8'h3C);
        code(16'h0000, 8'hFF);
        wr(4'h4, 32'h0000_0020);
        code(16'hFF80, 8'hFF);
        wr(4'h4, 32'h0000_0000);
        $display("test extra row done");
        wr(4'h0, 32'h0000_000C);
        wr(4'h8, {8'h00, 16'h0000, 8'h5A});
        launch(8'h54, 8'hA4, 1'b0);
        wr(4'h0, 32'h0000_0004);
        code(16'h0000, 8'h5F);
        `CHK(sec_hw, 4'hF)
        $display("test security done");
        wr(4'h0, 32'h0000_0008);
        wr(4'h8, {8'h00, 2'b00, pg, 7'h00, 8'h11});
        wr(4'h0, 32'h0000_0050);
        wr(4'h0, 32'h0000_0000);
        wr(4'h0, 32'h0000_00A0);
        wr(4'h0, 32'h0000_00A0);
        acc(1'b1, 4'h0, 0, 32'h0000_00A0, 32'hFFFF_FFFF);
        wr(4'h0, 32'h0000_0056);
        wr(4'h0, 32'h0000_00A6);
        acc(1'b1, 4'h0, 0, 32'h0000_00A6, 32'hFFFF_FFFF);
        `CHK(irq_masked, 1'b0)
        wr(4'h0, 32'h0000_0000);
        code({2'b00, pg, 7'h00}, dat[0]);
        $display("test key faults done");
        test_done;
    end
endmodule
`default_nettype wire
